/* motion_pkg.sv */
// Purpose: Shared constants for the motion target and following-error monitor.
// Assumes: One 125 MHz control clock; a millisecond time base is derived from it.
// Notes: Object-dictionary indices double as the register addresses of the block.
// What this block does
// - Raise following error after position error exceeds its window longer than the timeout.
// - Following error timeout is 16-bit milliseconds, reset value 0064 hex.
// - With a reaction configured, a following error also records an error-history entry.
// - In position modes, target reached when position error is below the window.
// - Position window of all ones disables target-reached position monitoring.
// - Position window is 32-bit unsigned, symmetric, reset value 000000A hex.
// - Position must stay in window for the position window time first.
// - Velocity demand shows the ramp output and feeds the speed controller.
// - Velocity actual register tracks measured speed every cycle.
// - In profile velocity mode, target reached when speed error is below window.
// - Speed must stay in window for the velocity window time, reset zero.
// - Target torque is signed 16-bit per mille, used in torque modes.
// - Torque is scaled so rated torque equals rated motor current.
// - Maximum torque is 16-bit unsigned per mille, reset value zero.
// - Following error window of all ones switches following error monitoring off.
package motion_pkg;

  // Object-dictionary indices used as register addresses.
  localparam logic [15:0] IDX_FERR_WINDOW = 16'h6065;
  localparam logic [15:0] IDX_FERR_TIMEOUT = 16'h6066;
  localparam logic [15:0] IDX_POS_WINDOW = 16'h6067;
  localparam logic [15:0] IDX_POS_WINDOW_TIME = 16'h6068;
  localparam logic [15:0] IDX_VEL_DEMAND = 16'h606B;
  localparam logic [15:0] IDX_VEL_ACTUAL = 16'h606C;
  localparam logic [15:0] IDX_VEL_WINDOW = 16'h606D;
  localparam logic [15:0] IDX_VEL_WINDOW_TIME = 16'h606E;
  localparam logic [15:0] IDX_TARGET_TORQUE = 16'h6071;
  localparam logic [15:0] IDX_MAX_TORQUE = 16'h6072;

  // Reset values of the writable settings.
  localparam logic [31:0] RST_FERR_WINDOW = 32'h00000100;
  localparam logic [15:0] RST_FERR_TIMEOUT = 16'h0064;
  localparam logic [31:0] RST_POS_WINDOW = 32'h0000000A;
  localparam logic [15:0] RST_POS_WINDOW_TIME = 16'h0064;
  localparam logic [15:0] RST_VEL_WINDOW = 16'h001E;
  localparam logic [15:0] RST_VEL_WINDOW_TIME = 16'h0000;
  localparam logic [15:0] RST_TARGET_TORQUE = 16'h0000;
  localparam logic [15:0] RST_MAX_TORQUE = 16'h0000;

  // A window holding this pattern switches its monitor off.
  localparam logic [31:0] WINDOW_OFF = 32'hFFFFFFFF;

  // Status word bit positions driven by this block.
  localparam int STATUS_TARGET_BIT = 10;
  localparam int STATUS_FERR_BIT = 13;

  // Operating mode codes.
  localparam logic [7:0] MODE_PROFILE_POSITION = 8'h01;
  localparam logic [7:0] MODE_PROFILE_VELOCITY = 8'h03;
  localparam logic [7:0] MODE_PROFILE_TORQUE = 8'h04;
  localparam logic [7:0] MODE_INTERP_POSITION = 8'h07;
  localparam logic [7:0] MODE_CS_TORQUE = 8'h0A;

  // Torque values are thousandths of rated torque.
  localparam logic [15:0] TORQUE_FULL_SCALE = 16'h03E8;

  // Millisecond time base.
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_NS = 1000000;
  localparam int CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;

endpackage

/* dwell_timer.sv */
// Purpose: Millisecond dwell timer that qualifies a condition held for a set time.
// Assumes: ms_tick is a one-cycle pulse once per millisecond on the same clock.
// Notes: STRICT=1 asks for longer than the limit, STRICT=0 for at least the limit.
`timescale 1ns/1ps
module dwell_timer #(
  parameter int WIDTH = 16,
  parameter bit STRICT = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic ms_tick,
  input wire logic cond,
  input wire logic [WIDTH-1:0] limit,
  output logic done
);

  logic [WIDTH:0] count;
  wire saturated = count[WIDTH];
  wire [WIDTH:0] wide_limit = {1'b0, limit};
  wire reached = STRICT ? (count > wide_limit) : (count >= wide_limit);

  // Count whole milliseconds while the condition holds; a drop restarts from zero.
  // The count saturates one past the widest limit so done never wraps away.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (ce) begin
      if (!cond) begin
        count <= '0;
      end else if (ms_tick && !saturated) begin
        count <= count + 1'b1;
      end
    end
  end

  // Done only while the condition still holds, so it falls at once on exit.
  assign done = cond && reached;

  chk_dwell_restart: assert property (@(posedge clk) disable iff (rst)
    ce && !cond |=> count == '0) else $error("dwell count not cleared");

  chk_done_count: assert property (@(posedge clk) disable iff (rst)
    done |-> count >= wide_limit) else $error("dwell done too early");

endmodule

/* motion_target_window_monitor.sv */
// Purpose: Following-error and target-reached monitoring plus velocity and torque setpoints.
// Assumes: All feedback inputs come from logic on clk; no synchronisers are needed.
// Notes: Accesses use the object index as address and are answered one cycle later.
`timescale 1ns/1ps
module motion_target_window_monitor #(
  parameter int CYCLES_PER_MS = motion_pkg::CYCLES_PER_MS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [15:0] od_index,
  input wire logic od_write,
  input wire logic od_read,
  input wire logic [31:0] od_wdata,
  output logic [31:0] od_rdata,
  output logic od_ack,
  output logic od_error,
  input wire logic [7:0] op_mode,
  input wire logic signed [31:0] demand_position,
  input wire logic signed [31:0] actual_position,
  input wire logic signed [31:0] target_position,
  input wire logic signed [31:0] ramp_velocity,
  input wire logic signed [31:0] measured_velocity,
  input wire logic signed [31:0] target_velocity,
  input wire logic [15:0] rated_current,
  input wire logic reaction_configured,
  output logic [15:0] status_bits,
  output logic following_error,
  output logic target_reached,
  output logic error_entry,
  output logic reaction_request,
  output logic signed [31:0] velocity_setpoint,
  output logic signed [15:0] torque_setpoint,
  output logic signed [15:0] current_setpoint
);

  // Magnitude of the difference of two signed words, exact over the full range.
  function automatic logic [32:0] abs_diff(input logic [31:0] a, input logic [31:0] b);
    logic [32:0] d;
    d = {a[31], a} - {b[31], b};
    return d[32] ? (33'h000000000 - d) : d;
  endfunction

  // Settings and read-only values.
  logic [31:0] ferr_window;
  logic [15:0] ferr_timeout;
  logic [31:0] pos_window;
  logic [15:0] pos_window_time;
  logic [31:0] velocity_demand;
  logic [31:0] velocity_actual;
  logic [15:0] vel_window;
  logic [15:0] vel_window_time;
  logic [15:0] target_torque;
  logic [15:0] max_torque;
  logic [$clog2(CYCLES_PER_MS)-1:0] ms_count;
  logic ms_tick;

  // Index decode for the object port.
  wire hit_ferr_window = od_index == motion_pkg::IDX_FERR_WINDOW;
  wire hit_ferr_timeout = od_index == motion_pkg::IDX_FERR_TIMEOUT;
  wire hit_pos_window = od_index == motion_pkg::IDX_POS_WINDOW;
  wire hit_pos_time = od_index == motion_pkg::IDX_POS_WINDOW_TIME;
  wire hit_vel_demand = od_index == motion_pkg::IDX_VEL_DEMAND;
  wire hit_vel_actual = od_index == motion_pkg::IDX_VEL_ACTUAL;
  wire hit_vel_window = od_index == motion_pkg::IDX_VEL_WINDOW;
  wire hit_vel_time = od_index == motion_pkg::IDX_VEL_WINDOW_TIME;
  wire hit_target_torque = od_index == motion_pkg::IDX_TARGET_TORQUE;
  wire hit_max_torque = od_index == motion_pkg::IDX_MAX_TORQUE;
  wire hit_read_only = hit_vel_demand || hit_vel_actual;
  wire hit_writable = hit_ferr_window || hit_ferr_timeout || hit_pos_window || hit_pos_time
    || hit_vel_window || hit_vel_time || hit_target_torque || hit_max_torque;
  wire access = od_write || od_read;
  wire write_ok = od_write && hit_writable;
  wire bad_access = od_write ? !hit_writable : !(hit_writable || hit_read_only);

  // Read selection; narrow objects sit in the low bits with zeros above.
  wire [31:0] read_value =
    hit_ferr_window ? ferr_window :
    hit_ferr_timeout ? {16'h0000, ferr_timeout} :
    hit_pos_window ? pos_window :
    hit_pos_time ? {16'h0000, pos_window_time} :
    hit_vel_demand ? velocity_demand :
    hit_vel_actual ? velocity_actual :
    hit_vel_window ? {16'h0000, vel_window} :
    hit_vel_time ? {16'h0000, vel_window_time} :
    hit_target_torque ? {16'h0000, target_torque} :
    hit_max_torque ? {16'h0000, max_torque} : 32'h00000000;

  // Writable settings; read-only objects ignore writes and flag an error.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ferr_window <= motion_pkg::RST_FERR_WINDOW;
      ferr_timeout <= motion_pkg::RST_FERR_TIMEOUT;
      pos_window <= motion_pkg::RST_POS_WINDOW;
      pos_window_time <= motion_pkg::RST_POS_WINDOW_TIME;
      vel_window <= motion_pkg::RST_VEL_WINDOW;
      vel_window_time <= motion_pkg::RST_VEL_WINDOW_TIME;
      target_torque <= motion_pkg::RST_TARGET_TORQUE;
      max_torque <= motion_pkg::RST_MAX_TORQUE;
    end else if (ce && write_ok) begin
      if (hit_ferr_window) ferr_window <= od_wdata;
      if (hit_ferr_timeout) ferr_timeout <= od_wdata[15:0];
      if (hit_pos_window) pos_window <= od_wdata;
      if (hit_pos_time) pos_window_time <= od_wdata[15:0];
      if (hit_vel_window) vel_window <= od_wdata[15:0];
      if (hit_vel_time) vel_window_time <= od_wdata[15:0];
      if (hit_target_torque) target_torque <= od_wdata[15:0];
      if (hit_max_torque) max_torque <= od_wdata[15:0];
    end
  end

  // Answer every access one cycle later with registered data.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      od_rdata <= 32'h00000000;
      od_ack <= 1'b0;
      od_error <= 1'b0;
    end else if (ce) begin
      od_ack <= access;
      od_error <= access && bad_access;
      od_rdata <= (od_read && !od_write) ? read_value : 32'h00000000;
    end
  end

  // Velocity values are sampled every cycle so the master sees live data.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      velocity_demand <= 32'h00000000;
      velocity_actual <= 32'h00000000;
    end else if (ce) begin
      velocity_demand <= ramp_velocity;
      velocity_actual <= measured_velocity;
    end
  end

  // The speed controller takes the same word the master reads back.
  assign velocity_setpoint = velocity_demand;

  // Millisecond tick; dwell times are quantised to whole ticks.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ms_count <= '0;
      ms_tick <= 1'b0;
    end else if (ce) begin
      ms_tick <= ms_count == ($clog2(CYCLES_PER_MS))'(CYCLES_PER_MS - 1);
      if (ms_count == ($clog2(CYCLES_PER_MS))'(CYCLES_PER_MS - 1)) begin
        ms_count <= '0;
      end else begin
        ms_count <= ms_count + 1'b1;
      end
    end
  end

  // Window comparisons; an all-ones following-error or position window switches its monitor off.
  wire [32:0] ferr_error = abs_diff(actual_position, demand_position);
  wire [32:0] pos_error = abs_diff(actual_position, target_position);
  wire [32:0] vel_error = abs_diff(measured_velocity, target_velocity);
  wire ferr_enabled = ferr_window != motion_pkg::WINDOW_OFF;
  wire pos_enabled = pos_window != motion_pkg::WINDOW_OFF;
  wire ferr_outside = ferr_enabled && (ferr_error > {1'b0, ferr_window});
  wire pos_inside = pos_enabled && (pos_error < {1'b0, pos_window});
  wire vel_inside = vel_error < {17'h00000, vel_window};
  wire pos_mode = (op_mode == motion_pkg::MODE_PROFILE_POSITION)
    || (op_mode == motion_pkg::MODE_INTERP_POSITION);
  wire vel_mode = op_mode == motion_pkg::MODE_PROFILE_VELOCITY;
  wire torque_mode = (op_mode == motion_pkg::MODE_PROFILE_TORQUE)
    || (op_mode == motion_pkg::MODE_CS_TORQUE);
  wire ferr_done;
  wire pos_done;
  wire vel_done;

  // The following error must last longer than the timeout.
  dwell_timer #(.WIDTH(16), .STRICT(1'b1)) ferr_timer (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .ms_tick(ms_tick),
    .cond(ferr_outside),
    .limit(ferr_timeout),
    .done(ferr_done)
  );

  // Position dwell uses its own window time, not the following-error timeout.
  dwell_timer #(.WIDTH(16), .STRICT(1'b0)) pos_timer (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .ms_tick(ms_tick),
    .cond(pos_inside && pos_mode),
    .limit(pos_window_time),
    .done(pos_done)
  );

  // Velocity dwell; a zero time reports at the first cycle inside the window.
  dwell_timer #(.WIDTH(16), .STRICT(1'b0)) vel_timer (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .ms_tick(ms_tick),
    .cond(vel_inside && vel_mode),
    .limit(vel_window_time),
    .done(vel_done)
  );

  wire next_target_reached = pos_mode ? pos_done : (vel_mode ? vel_done : 1'b0);
  wire ferr_rise = ferr_done && !following_error;

  // Status flags and the one-shot error reaction on a new following error.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      following_error <= 1'b0;
      target_reached <= 1'b0;
      error_entry <= 1'b0;
      reaction_request <= 1'b0;
    end else if (ce) begin
      following_error <= ferr_done;
      target_reached <= next_target_reached;
      reaction_request <= ferr_rise && reaction_configured;
      error_entry <= ferr_rise && reaction_configured;
    end
  end

  // Only bits 10 and 13 of the status word belong to this block.
  always_comb begin
    status_bits = 16'h0000;
    status_bits[motion_pkg::STATUS_TARGET_BIT] = target_reached;
    status_bits[motion_pkg::STATUS_FERR_BIT] = following_error;
  end

  // Torque clamp; a zero limit holds the applied torque at zero.
  wire [16:0] torque_mag = target_torque[15] ? (17'h00000 - {1'b1, target_torque})
    : {1'b0, target_torque};
  wire over_limit = torque_mag > {1'b0, max_torque};
  wire [15:0] clamp_neg = 16'h0000 - max_torque;
  wire [15:0] clamped = over_limit ? (target_torque[15] ? clamp_neg : max_torque)
    : target_torque;
  wire [15:0] next_torque = torque_mode ? clamped : 16'h0000;
  // Scaling by rated current costs a divider; it runs once per cycle, not per sample.
  wire signed [32:0] current_product = $signed(next_torque) * $signed({1'b0, rated_current});
  wire signed [32:0] current_scaled = current_product
    / $signed({17'h00000, motion_pkg::TORQUE_FULL_SCALE});

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      torque_setpoint <= 16'sh0000;
      current_setpoint <= 16'sh0000;
    end else if (ce) begin
      torque_setpoint <= $signed(next_torque);
      current_setpoint <= current_scaled[15:0];
    end
  end

  // Exits from the windows, used to check that target reached falls at once.
  sequence s_pos_exit;
    ce && pos_mode && !pos_inside;
  endsequence
  sequence s_vel_exit;
    ce && vel_mode && !vel_inside;
  endsequence

  chk_ferr_cause: assert property (@(posedge clk) disable iff (rst)
    $rose(following_error) |-> $past(ferr_outside)) else $error("ferr without error");

  chk_timeout_write: assert property (@(posedge clk) disable iff (rst)
    ce && od_write && hit_ferr_timeout |=> ferr_timeout == $past(od_wdata[15:0]))
    else $error("timeout not written");

  chk_entry_pairs: assert property (@(posedge clk) disable iff (rst)
    ce && ferr_done && !following_error && reaction_configured |=> error_entry
    && reaction_request && following_error) else $error("missing error entry");

  chk_pos_reached: assert property (@(posedge clk) disable iff (rst)
    ce && pos_mode && target_reached |-> $past(pos_inside)) else $error("pos reached early");

  // Outside the position and velocity modes nothing may report the target as reached.
  chk_mode_gate: assert property (@(posedge clk) disable iff (rst)
    ce && !pos_mode && !vel_mode |=> !target_reached) else $error("reached in wrong mode");

  chk_pos_off: assert property (@(posedge clk) disable iff (rst)
    ce && pos_mode && pos_window == motion_pkg::WINDOW_OFF |=> !target_reached)
    else $error("pos monitor not off");

  chk_vel_demand: assert property (@(posedge clk) disable iff (rst)
    ce |=> velocity_setpoint == $past(ramp_velocity)) else $error("demand stale");

  chk_ro_refused: assert property (@(posedge clk) disable iff (rst)
    ce && od_write && hit_read_only |=> od_ack && od_error) else $error("ro write taken");

  chk_vel_actual: assert property (@(posedge clk) disable iff (rst)
    ce |=> velocity_actual == $past(measured_velocity)) else $error("actual stale");

  chk_vel_reached: assert property (@(posedge clk) disable iff (rst)
    ce && vel_mode && target_reached |-> $past(vel_inside)) else $error("vel reached early");

  chk_ferr_off: assert property (@(posedge clk) disable iff (rst)
    ce && ferr_window == motion_pkg::WINDOW_OFF |=> !following_error)
    else $error("ferr monitor not off");

  chk_exit_clears: assert property (@(posedge clk) disable iff (rst)
    s_pos_exit or s_vel_exit |=> !target_reached) else $error("reached held");

  chk_torque_clamp: assert property (@(posedge clk) disable iff (rst)
    ce && torque_mode |=> (torque_setpoint[15] ? (17'h00000 - {1'b1, torque_setpoint})
    : {1'b0, torque_setpoint}) <= {1'b0, $past(max_torque)}) else $error("torque unclamped");

endmodule

/* motor_feedback_model.sv */
// Purpose: Far-side model that feeds position and speed feedback to the monitor.
// Assumes: The bench sets the wanted errors between clock edges.
// Notes: Position demand and target stand still; the speed target follows the ramp input.
`timescale 1ns/1ps
module motor_feedback_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic signed [31:0] pos_err,
  input wire logic signed [31:0] vel_err,
  input wire logic signed [31:0] ramp,
  output logic signed [31:0] demand_position,
  output logic signed [31:0] actual_position,
  output logic signed [31:0] target_position,
  output logic signed [31:0] ramp_velocity,
  output logic signed [31:0] measured_velocity,
  output logic signed [31:0] target_velocity
);
  localparam logic signed [31:0] TARGET_POS = 32'sh00001000;

  // Feedback is registered like a sampled encoder, so it never changes on the bench's edge.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      actual_position <= TARGET_POS;
      ramp_velocity <= 32'sh0;
      measured_velocity <= 32'sh0;
    end else begin
      actual_position <= TARGET_POS - pos_err;
      ramp_velocity <= ramp;
      measured_velocity <= ramp - vel_err;
    end
  end

  // A fixed target keeps the error seen by the monitor exactly the one asked for.
  assign demand_position = TARGET_POS;
  assign target_position = TARGET_POS;
  assign target_velocity = ramp_velocity;
endmodule

/* motion_target_window_monitor_tb_top.sv */
// Purpose: Self-checking bench for the following-error and target-reached monitor.
// Assumes: Inputs change on the falling edge; a millisecond is shortened to 4 cycles.
// Notes: Every wait is bounded; a wait that runs out ends the run at once.
`timescale 1ns/1ps
module motion_target_window_monitor_tb_top;
  localparam int MS = 4;
  localparam logic [15:0] IDX[10] = '{16'h6065, 16'h6066, 16'h6067, 16'h6068, 16'h606B,
    16'h606C, 16'h606D, 16'h606E, 16'h6071, 16'h6072};
  localparam logic [31:0] RV[10] = '{32'h100, 32'h64, 32'hA, 32'h64, 32'h0, 32'h0,
    32'h1E, 32'h0, 32'h0, 32'h0};
  localparam int WD[10] = '{32, 16, 32, 16, 0, 0, 16, 16, 16, 16};
  logic clk, rst, ce, od_write, od_read, od_ack, od_error, reaction_configured;
  logic following_error, target_reached, error_entry, reaction_request, entry_seen, er;
  logic [15:0] od_index, rated_current, status_bits;
  logic [31:0] od_wdata, od_rdata, rd;
  logic [7:0] op_mode;
  logic signed [31:0] pos_err, vel_err, ramp, dpos, apos, tpos, rvel, mvel, tvel;
  logic signed [31:0] velocity_setpoint;
  logic signed [15:0] torque_setpoint, current_setpoint;
  int err_total, checks;

  motor_feedback_model far (.clk(clk), .rst(rst), .pos_err(pos_err), .vel_err(vel_err),
    .ramp(ramp), .demand_position(dpos), .actual_position(apos), .target_position(tpos),
    .ramp_velocity(rvel), .measured_velocity(mvel), .target_velocity(tvel));

  motion_target_window_monitor #(.CYCLES_PER_MS(MS)) dut (.clk(clk), .rst(rst), .ce(ce),
    .od_index(od_index), .od_write(od_write), .od_read(od_read), .od_wdata(od_wdata),
    .od_rdata(od_rdata), .od_ack(od_ack), .od_error(od_error), .op_mode(op_mode),
    .demand_position(dpos), .actual_position(apos), .target_position(tpos),
    .ramp_velocity(rvel), .measured_velocity(mvel), .target_velocity(tvel),
    .rated_current(rated_current), .reaction_configured(reaction_configured),
    .status_bits(status_bits), .following_error(following_error),
    .target_reached(target_reached), .error_entry(error_entry),
    .reaction_request(reaction_request), .velocity_setpoint(velocity_setpoint),
    .torque_setpoint(torque_setpoint), .current_setpoint(current_setpoint));

  // Clock of 8 ns.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // An entry only counts when the reaction request comes in the same cycle.
  // Sampled between edges, so the one-cycle pulse is seen while it stands.
  always @(negedge clk) begin
    if (error_entry === 1'b1 && reaction_request === 1'b1) begin
      entry_seen = 1'b1;
    end
  end

  task automatic final_report();
    $display("checks=%0d errors=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk32(input logic [31:0] exp, input logic [31:0] act);
    checks++;
    if (act !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, act);
    end
  endtask

  task automatic chk1(input logic exp, input logic act);
    chk32({31'h0, exp}, {31'h0, act});
  endtask

  function automatic logic flag(input int sel);
    return sel == 0 ? following_error : target_reached;
  endfunction

  // One access: strobe for one cycle, then wait a bounded time for the acknowledge.
  task automatic acc(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    int n;
    @(negedge clk);
    od_index = idx;
    od_wdata = wd;
    od_write = wr;
    od_read = !wr;
    @(negedge clk);
    od_write = 1'b0;
    od_read = 1'b0;
    n = 0;
    while (od_ack !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    rd = od_rdata;
    er = od_error;
    if (od_ack !== 1'b1) begin
      chk1(1'b1, od_ack);
      final_report();
    end
  endtask

  task automatic wait_lvl(input int sel, input logic val, input int lim);
    int n;
    n = 0;
    while (flag(sel) !== val && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk1(val, flag(sel));
    if (flag(sel) !== val) begin
      final_report();
    end
  endtask

  task automatic stay_lo(input int sel, input int cyc);
    repeat (cyc) begin
      @(negedge clk);
      if (flag(sel) !== 1'b0) break;
    end
    chk1(1'b0, flag(sel));
  endtask

  task automatic do_reset();
    rst = 1'b1;
    repeat (10) @(negedge clk);
    rst = 1'b0;
  endtask

  // Main sequence; the bench commands torques both within and beyond the maximum torque.
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    od_write = 1'b0;
    od_read = 1'b0;
    od_index = 16'h0;
    od_wdata = 32'h0;
    op_mode = 8'h0;
    pos_err = 32'sh0;
    vel_err = 32'sh0;
    ramp = 32'sh0;
    rated_current = 16'h07D0;
    reaction_configured = 1'b0;
    entry_seen = 1'b0;
    err_total = 0;
    checks = 0;
    do_reset();
    for (int i = 0; i < 10; i++) begin
      acc(1'b0, IDX[i], 32'h0);
      chk32(RV[i], rd);
      acc(1'b1, IDX[i], 32'h87654321);
      chk1(WD[i] == 0, er);
      acc(1'b0, IDX[i], 32'h0);
      chk32(WD[i] == 32 ? 32'h87654321 : WD[i] == 16 ? 32'h4321 : 32'h0, rd);
    end
    acc(1'b0, 16'h6070, 32'h0);
    chk1(1'b1, er);
    do_reset();
    // Speed registers, then the speed window with zero and nonzero dwell.
    ramp = 32'sh12345678;
    vel_err = 32'sh5;
    repeat (3) @(negedge clk);
    chk32(32'h12345678, velocity_setpoint);
    acc(1'b0, 16'h606B, 32'h0);
    chk32(32'h12345678, rd);
    acc(1'b0, 16'h606C, 32'h0);
    chk32(32'h12345673, rd);
    op_mode = 8'h03;
    vel_err = 32'sh1D;
    wait_lvl(1, 1'b1, 4);
    chk1(1'b1, status_bits[10]);
    vel_err = -32'sh1E;
    wait_lvl(1, 1'b0, 3);
    acc(1'b1, 16'h606E, 32'h2);
    vel_err = -32'sh1D;
    stay_lo(1, 4);
    wait_lvl(1, 1'b1, 16);
    // Position window at its boundary, with the reset dwell of 100 ms.
    for (int m = 0; m < 2; m++) begin
      op_mode = m == 0 ? 8'h01 : 8'h07;
      pos_err = 32'shA;
      stay_lo(1, 420);
      pos_err = -32'sh9;
      stay_lo(1, 380);
      wait_lvl(1, 1'b1, 40);
      chk1(1'b1, status_bits[10]);
      pos_err = 32'shB;
      wait_lvl(1, 1'b0, 3);
    end
    acc(1'b1, 16'h6067, 32'hFFFFFFFF);
    pos_err = 32'sh0;
    stay_lo(1, 420);
    // Following error just past the window, both signs, with and without a reaction.
    acc(1'b1, 16'h6066, 32'h2);
    for (int i = 0; i < 2; i++) begin
      reaction_configured = i == 0;
      entry_seen = 1'b0;
      pos_err = i == 0 ? 32'sh101 : -32'sh101;
      stay_lo(0, 7);
      wait_lvl(0, 1'b1, 16);
      chk1(1'b1, status_bits[13]);
      @(negedge clk);
      chk1(i == 0, entry_seen);
      pos_err = 32'sh100;
      wait_lvl(0, 1'b0, 3);
    end
    acc(1'b1, 16'h6065, 32'hFFFFFFFF);
    pos_err = 32'sh7FFF0000;
    stay_lo(0, 40);
    // Torque clamp and scaling in both torque modes; zero elsewhere.
    for (int i = 0; i < 2; i++) begin
      op_mode = i == 0 ? 8'h04 : 8'h0A;
      acc(1'b1, 16'h6072, 32'h1F4);
      acc(1'b1, 16'h6071, 32'hFCE0);
      repeat (3) @(negedge clk);
      chk32(32'hFE0C, {16'h0, torque_setpoint});
      chk32(32'hFC18, {16'h0, current_setpoint});
      acc(1'b1, 16'h6071, 32'h12C);
      repeat (3) @(negedge clk);
      chk32(32'h12C, {16'h0, torque_setpoint});
      chk32(32'h258, {16'h0, current_setpoint});
      acc(1'b1, 16'h6072, 32'h0);
      repeat (3) @(negedge clk);
      chk32(32'h0, {16'h0, torque_setpoint});
    end
    acc(1'b1, 16'h6072, 32'h1F4);
    op_mode = 8'h01;
    repeat (3) @(negedge clk);
    chk32(32'h0, {16'h0, torque_setpoint});
    final_report();
  end
endmodule
